// ==== hw/pm_msg_pkg.sv ====
// Shared message layout and constants for the power-management message link
package pm_msg_pkg;
	localparam int PAYLOAD_W   = 128;
	localparam int OPCODE_W    = 4;
	localparam int PARAM_W     = 4;
	localparam int AGENT_W     = 7;
	localparam int CREDIT_W    = 8;
	localparam int REV_W       = 8;
	// Credit-return payload fields
	localparam int CREDIT_LSB  = 0;
	localparam int AGENT_LSB   = 8;
	// Agent-information payload fields
	localparam int REV_LSB     = 0;
	localparam logic [PARAM_W-1:0] PARAM_INDEX_REV = 4'h0;
	// Message kinds
	localparam logic [OPCODE_W-1:0] OP_CREDIT_RETURN = 4'h1;
	localparam logic [OPCODE_W-1:0] OP_AGENT_INFORMATION_MESSAGE    = 4'h2;
	localparam logic [OPCODE_W-1:0] OP_GENERIC       = 4'h3;
	// Clock and credit timing
	localparam int CLK_PERIOD_NS     = 40;
	localparam int CREDIT_HOLD_MAX_NS = 10000;
	localparam int CREDIT_HOLD_CYCLES = CREDIT_HOLD_MAX_NS / CLK_PERIOD_NS;
	localparam logic [CREDIT_W-1:0] CREDIT_MAX = 8'hff;
	localparam logic [CREDIT_W-1:0] CREDIT_ONE = 8'h01;
	localparam logic [CREDIT_W-1:0] CREDIT_ZERO = 8'h00;
	localparam logic [AGENT_W-1:0]  AGENT_RSVD = 7'h00;

	typedef struct packed {
		logic [OPCODE_W-1:0]  opcode;
		logic [PARAM_W-1:0]   paramIndex;
		logic [PAYLOAD_W-1:0] payload;
	} pm_msg_t;

	function automatic pm_msg_t make_credit_msg(input logic [CREDIT_W-1:0] credits,
		input logic [AGENT_W-1:0] agent);
		pm_msg_t m;
		m = '0;
		m.opcode = OP_CREDIT_RETURN;
		m.payload[CREDIT_LSB +: CREDIT_W] = credits;
		m.payload[AGENT_LSB +: AGENT_W] = agent;
		return m;
	endfunction

	function automatic pm_msg_t make_info_msg(input logic [REV_W-1:0] rev);
		pm_msg_t m;
		m = '0;
		m.opcode = OP_AGENT_INFORMATION_MESSAGE;
		m.paramIndex = PARAM_INDEX_REV;
		m.payload[REV_LSB +: REV_W] = rev;
		return m;
	endfunction

	function automatic logic [CREDIT_W-1:0] sat_add(input logic [CREDIT_W-1:0] a,
		input logic [CREDIT_W-1:0] b);
		logic [CREDIT_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[CREDIT_W] ? CREDIT_MAX : s[CREDIT_W-1:0];
	endfunction
endpackage

// ==== hw/pm_msg_if.sv ====
// Message link between host power controller and device
`timescale 1ns/1ps
interface pm_msg_if;
	import pm_msg_pkg::*;
	logic    hostToDeviceValid;
	pm_msg_t hostToDeviceMsg;
	logic    deviceToHostValid;
	pm_msg_t deviceToHostMsg;

	modport device (
		input  hostToDeviceValid,
		input  hostToDeviceMsg,
		output deviceToHostValid,
		output deviceToHostMsg
	);
	modport host (
		output hostToDeviceValid,
		output hostToDeviceMsg,
		input  deviceToHostValid,
		input  deviceToHostMsg
	);
endinterface

// ==== hw/pm_msg_device.sv ====
// Device end of the power-management message link
// Behaviour
// (R1) Credit returns always accepted, no dependencies
// (R2) Credit returns consume no transmit credit
// (R3) Returned count equals free receive slots
// (R4) Adopt agent identifier from first message
// (R5) No device messages before first credit
// (R6) Receive buffer holds full 128-bit messages
// (R7) After credits, await host agent_information_message request
// (R8) Reply agent_information_message with own revision
// (R9) Host handles revision mismatch its way
// (R10) Return freed credits well within 10us
// (R11) Host never exceeds granted credits
// (R12) Credit count 7:0, agent 14:8 reserved
// (R13) Agent_information_message index 0 carries revision 7:0
// (R14) Saturating transmit credits, block at zero
`timescale 1ns/1ps
module pm_msg_device #(
	parameter int                          RX_DEPTH = 2,
	parameter logic [pm_msg_pkg::REV_W-1:0] REVISION = 8'h01
) (
	input  wire logic                           ref_clk,
	input  wire logic                           srst,
	pm_msg_if.device                            link,
	input  wire logic                           userTxValid,
	input  wire logic [pm_msg_pkg::PAYLOAD_W-1:0] userTxPayload,
	output logic                                userTxReady,
	output logic                                userRxValid,
	output pm_msg_pkg::pm_msg_t                 userRxMsg,
	input  wire logic                           userRxReady,
	output logic                                linkReady,
	output logic [pm_msg_pkg::AGENT_W-1:0]      agentId,
	output logic [pm_msg_pkg::REV_W-1:0]        hostRevision
);
	import pm_msg_pkg::*;

	typedef enum logic [1:0] {
		ST_WAIT_CREDIT = 2'b00,
		ST_WAIT_INFO   = 2'b01,
		ST_SEND_INFO   = 2'b10,
		ST_RUN         = 2'b11
	} dev_state_t;

	localparam int PTR_W = $clog2(RX_DEPTH);
	localparam logic [CREDIT_W-1:0] RX_CREDITS = CREDIT_W'(RX_DEPTH);

	dev_state_t             state_reg, state_next;
	logic [CREDIT_W-1:0]    txCredit_reg, txCredit_next;
	logic [CREDIT_W-1:0]    owed_reg, owed_next;
	logic                   agentKnown_reg, agentKnown_next;
	logic [AGENT_W-1:0]     agent_reg, agent_next;
	logic [REV_W-1:0]       hostRev_reg, hostRev_next;
	logic                   infoPending_reg, infoPending_next;
	logic                   outValid_reg, outValid_next;
	pm_msg_t                outMsg_reg, outMsg_next;
	logic                   rxValid_reg, rxValid_next;
	pm_msg_t                rxMsg_reg, rxMsg_next;
	logic                   txReady_reg, txReady_next;
	logic                   linkReady_reg, linkReady_next;
	pm_msg_t                rxMem [RX_DEPTH];
	logic [PTR_W:0]         wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;

	logic    inValid;
	pm_msg_t inMsg;
	logic    isCredit, isInfo, isGeneric, bufPush, bufPop, bufEmpty;

	assign inValid   = link.hostToDeviceValid;
	assign inMsg     = link.hostToDeviceMsg;
	assign isCredit  = inValid && inMsg.opcode == OP_CREDIT_RETURN;
	assign isInfo    = inValid && inMsg.opcode == OP_AGENT_INFORMATION_MESSAGE;
	assign isGeneric = inValid && !isCredit && !isInfo;
	// Host never overruns granted slots, so no overflow check here [R11]
	assign bufPush   = isGeneric;
	assign bufEmpty  = wrPtr_reg == rdPtr_reg;
	assign bufPop    = !bufEmpty && (!rxValid_reg || userRxReady);

	always_comb begin
		state_next       = state_reg;
		txCredit_next    = txCredit_reg;
		owed_next        = owed_reg;
		agentKnown_next  = agentKnown_reg;
		agent_next       = agent_reg;
		hostRev_next     = hostRev_reg;
		infoPending_next = infoPending_reg;
		outValid_next    = 1'b0;
		outMsg_next      = outMsg_reg;
		wrPtr_next       = wrPtr_reg;
		rdPtr_next       = rdPtr_reg;
		rxValid_next     = rxValid_reg;
		rxMsg_next       = rxMsg_reg;

		// First host message of any kind names us [R4]
		if (inValid && !agentKnown_reg) begin
			agentKnown_next = 1'b1;
			agent_next      = inMsg.payload[AGENT_LSB +: AGENT_W];
		end
		// Credits accepted in every state, no other message needed [R1] [R14]
		if (isCredit)
			txCredit_next = sat_add(txCredit_reg, inMsg.payload[CREDIT_LSB +: CREDIT_W]);
		if (isInfo) begin
			// Reserved unless index 0 [R13]
			if (inMsg.paramIndex == PARAM_INDEX_REV)
				hostRev_next = inMsg.payload[REV_LSB +: REV_W];
			infoPending_next = 1'b1;
			// Info request slot is freed at once [R10]
			owed_next = sat_add(owed_next, CREDIT_ONE);
		end

		if (bufPush)
			wrPtr_next = wrPtr_reg + 1'b1;
		if (rxValid_reg && userRxReady)
			rxValid_next = 1'b0;
		if (bufPop) begin
			rxMsg_next   = rxMem[rdPtr_reg[PTR_W-1:0]];
			rxValid_next = 1'b1;
			rdPtr_next   = rdPtr_reg + 1'b1;
			// Slot freed, credit owed back to the host [R10]
			owed_next = sat_add(owed_next, CREDIT_ONE);
		end

		case (state_reg)
			ST_WAIT_CREDIT: begin
				// Hold off all device messages until the first host credit [R5]
				if (isCredit) begin
					state_next = ST_WAIT_INFO;
					owed_next  = RX_CREDITS;
				end
			end
			ST_WAIT_INFO: begin
				if (infoPending_reg || isInfo) // [R7]
					state_next = ST_SEND_INFO;
			end
			ST_SEND_INFO: begin
				state_next = ST_RUN;
			end
			ST_RUN: begin
			end
			default: state_next = ST_WAIT_CREDIT;
		endcase

		// One message per cycle; credit return first, it needs no credit [R2]
		if (state_reg != ST_WAIT_CREDIT && owed_reg != CREDIT_ZERO) begin
			outValid_next = 1'b1;
			// Count is exactly the slots freed; agent field reserved [R3] [R12]
			outMsg_next   = make_credit_msg(owed_reg, AGENT_RSVD);
			owed_next     = owed_next - owed_reg;
		end else if ((state_reg == ST_SEND_INFO || state_reg == ST_RUN) && infoPending_reg
			&& txCredit_reg != CREDIT_ZERO) begin
			outValid_next    = 1'b1;
			outMsg_next      = make_info_msg(REVISION); // [R8]
			infoPending_next = isInfo;
			txCredit_next    = txCredit_next - CREDIT_ONE; // [R14]
		end else if (state_reg == ST_RUN && userTxValid && txReady_reg) begin
			outValid_next        = 1'b1;
			outMsg_next          = '0;
			outMsg_next.opcode   = OP_GENERIC;
			outMsg_next.payload  = userTxPayload;
			txCredit_next        = txCredit_next - CREDIT_ONE; // [R14]
		end
	end

	// Ready only when a credit is held and no higher-priority send waits [R14]
	assign txReady_next = state_next == ST_RUN && txCredit_next != CREDIT_ZERO
		&& owed_next == CREDIT_ZERO && !infoPending_next;
	assign linkReady_next = state_next == ST_RUN;

	always_ff @(posedge ref_clk) begin
		if (bufPush)
			rxMem[wrPtr_reg[PTR_W-1:0]] <= inMsg; // Full 136-bit message entries, 128-bit payload [R6]
		if (srst) begin
			state_reg       <= ST_WAIT_CREDIT;
			txCredit_reg    <= CREDIT_ZERO;
			owed_reg        <= CREDIT_ZERO;
			agentKnown_reg  <= 1'b0;
			agent_reg       <= AGENT_RSVD;
			hostRev_reg     <= '0;
			infoPending_reg <= 1'b0;
			outValid_reg    <= 1'b0;
			outMsg_reg      <= '0;
			rxValid_reg     <= 1'b0;
			rxMsg_reg       <= '0;
			txReady_reg     <= 1'b0;
			linkReady_reg   <= 1'b0;
			wrPtr_reg       <= '0;
			rdPtr_reg       <= '0;
		end else begin
			state_reg       <= state_next;
			txCredit_reg    <= txCredit_next;
			owed_reg        <= owed_next;
			agentKnown_reg  <= agentKnown_next;
			agent_reg       <= agent_next;
			hostRev_reg     <= hostRev_next;
			infoPending_reg <= infoPending_next;
			outValid_reg    <= outValid_next;
			outMsg_reg      <= outMsg_next;
			rxValid_reg     <= rxValid_next;
			rxMsg_reg       <= rxMsg_next;
			txReady_reg     <= txReady_next;
			linkReady_reg   <= linkReady_next;
			wrPtr_reg       <= wrPtr_next;
			rdPtr_reg       <= rdPtr_next;
		end
	end

	assign link.deviceToHostValid = outValid_reg;
	assign link.deviceToHostMsg   = outMsg_reg;
	assign userTxReady  = txReady_reg;
	assign userRxValid  = rxValid_reg;
	assign userRxMsg    = rxMsg_reg;
	assign linkReady    = linkReady_reg;
	assign agentId      = agent_reg;
	assign hostRevision = hostRev_reg;
endmodule

// ==== hw/pm_msg_host.sv ====
// Host end of the power-management message link
`timescale 1ns/1ps
module pm_msg_host #(
	parameter int                           HOST_CREDITS = 4,
	parameter logic [pm_msg_pkg::AGENT_W-1:0] DEVICE_AGENT = 7'h05,
	parameter logic [pm_msg_pkg::REV_W-1:0]   REVISION     = 8'h01
) (
	input  wire logic                             ref_clk,
	input  wire logic                             srst,
	pm_msg_if.host                                link,
	input  wire logic                             userTxValid,
	input  wire logic [pm_msg_pkg::PAYLOAD_W-1:0] userTxPayload,
	output logic                                  userTxReady,
	output logic                                  userRxValid,
	output pm_msg_pkg::pm_msg_t                   userRxMsg,
	output logic                                  revMismatch,
	output logic                                  initDone
);
	import pm_msg_pkg::*;

	typedef enum logic [1:0] {
		HS_CREDIT = 2'b00,
		HS_INFO   = 2'b01,
		HS_WAIT   = 2'b10,
		HS_RUN    = 2'b11
	} host_state_t;

	localparam logic [CREDIT_W-1:0] GRANT = CREDIT_W'(HOST_CREDITS);

	host_state_t         state_reg, state_next;
	logic [CREDIT_W-1:0] credit_reg, credit_next;
	logic                outValid_reg, outValid_next;
	pm_msg_t             outMsg_reg, outMsg_next;
	logic                rxValid_reg, rxValid_next;
	pm_msg_t             rxMsg_reg, rxMsg_next;
	logic                mismatch_reg, mismatch_next;
	logic                txReady_reg, txReady_next;
	logic [CREDIT_W-1:0] owed_reg, owed_next;
	logic                initDone_reg, initDone_next;
	logic                inCredit, inInfo;

	assign inCredit = link.deviceToHostValid && link.deviceToHostMsg.opcode == OP_CREDIT_RETURN;
	assign inInfo   = link.deviceToHostValid && link.deviceToHostMsg.opcode == OP_AGENT_INFORMATION_MESSAGE;

	always_comb begin
		state_next    = state_reg;
		credit_next   = credit_reg;
		outValid_next = 1'b0;
		outMsg_next   = outMsg_reg;
		rxValid_next  = 1'b0;
		rxMsg_next    = rxMsg_reg;
		mismatch_next = mismatch_reg;
		owed_next     = owed_reg;
		if (inCredit)
			credit_next = sat_add(credit_reg, link.deviceToHostMsg.payload[CREDIT_LSB +: CREDIT_W]);
		if (link.deviceToHostValid && !inCredit) begin
			rxValid_next = 1'b1;
			rxMsg_next   = link.deviceToHostMsg;
			// Absorbed at once; info reply during init is owed back too [R3]
			owed_next    = sat_add(owed_reg, CREDIT_ONE);
		end
		// Mismatch is logged, operation goes on [R9]
		if (inInfo && link.deviceToHostMsg.payload[REV_LSB +: REV_W] != REVISION)
			mismatch_next = 1'b1;
		case (state_reg)
			HS_CREDIT: begin
				// Grant credits and name the device [R4]
				outValid_next = 1'b1;
				outMsg_next   = make_credit_msg(GRANT, DEVICE_AGENT);
				state_next    = HS_INFO;
			end
			HS_INFO: begin
				if (credit_next != CREDIT_ZERO) begin // [R11]
					outValid_next = 1'b1;
					outMsg_next   = make_info_msg(REVISION);
					credit_next   = credit_next - CREDIT_ONE;
					state_next    = HS_WAIT;
				end
			end
			HS_WAIT: begin
				if (inInfo)
					state_next = HS_RUN;
			end
			HS_RUN: begin
				// A taken user send wins; its ready could not foresee a return
				if (userTxValid && txReady_reg) begin
					outValid_next       = 1'b1;
					outMsg_next         = '0;
					outMsg_next.opcode  = OP_GENERIC;
					outMsg_next.payload = userTxPayload;
					credit_next         = credit_next - CREDIT_ONE; // [R11]
				end else if (owed_reg != CREDIT_ZERO) begin
					outValid_next = 1'b1;
					outMsg_next   = make_credit_msg(owed_reg, DEVICE_AGENT); // [R2] [R3]
					owed_next     = owed_next - owed_reg;
				end
			end
			default: state_next = HS_CREDIT;
		endcase
	end

	assign txReady_next = state_next == HS_RUN && credit_next != CREDIT_ZERO;
	assign initDone_next = state_next == HS_RUN;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_reg    <= HS_CREDIT;
			credit_reg   <= CREDIT_ZERO;
			outValid_reg <= 1'b0;
			outMsg_reg   <= '0;
			rxValid_reg  <= 1'b0;
			rxMsg_reg    <= '0;
			mismatch_reg <= 1'b0;
			txReady_reg  <= 1'b0;
			owed_reg     <= CREDIT_ZERO;
			initDone_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			credit_reg   <= credit_next;
			outValid_reg <= outValid_next;
			outMsg_reg   <= outMsg_next;
			rxValid_reg  <= rxValid_next;
			rxMsg_reg    <= rxMsg_next;
			mismatch_reg <= mismatch_next;
			txReady_reg  <= txReady_next;
			owed_reg     <= owed_next;
			initDone_reg <= initDone_next;
		end
	end

	assign link.hostToDeviceValid = outValid_reg;
	assign link.hostToDeviceMsg   = outMsg_reg;
	assign userTxReady = txReady_reg;
	assign userRxValid = rxValid_reg;
	assign userRxMsg   = rxMsg_reg;
	assign revMismatch = mismatch_reg;
	assign initDone    = initDone_reg;
endmodule

// ==== verif/pm_msg_checker.sv ====
// Assertions on the power-management message link
`timescale 1ns/1ps
module pm_msg_checker #(
	parameter int                           RX_DEPTH = 2,
	parameter logic [pm_msg_pkg::REV_W-1:0] DEV_REV  = 8'h01
) (
	input wire logic                ref_clk,
	input wire logic                srst,
	input wire logic                hostToDeviceValid,
	input wire pm_msg_pkg::pm_msg_t hostToDeviceMsg,
	input wire logic                deviceToHostValid,
	input wire pm_msg_pkg::pm_msg_t deviceToHostMsg
);
	import pm_msg_pkg::*;
	localparam int HOLD_MAX = CREDIT_HOLD_CYCLES;
	logic       hCr, hUse, dCr, dUse, dInfo, hInfo;
	logic       gotCr_reg, gotCr_next;
	logic [7:0] hostCr_reg, hostCr_next, devCr_reg, devCr_next;

	assign hCr = hostToDeviceValid && hostToDeviceMsg.opcode == OP_CREDIT_RETURN;
	assign hUse = hostToDeviceValid && !hCr;
	assign hInfo = hostToDeviceValid && hostToDeviceMsg.opcode == OP_AGENT_INFORMATION_MESSAGE;
	assign dCr = deviceToHostValid && deviceToHostMsg.opcode == OP_CREDIT_RETURN;
	assign dUse = deviceToHostValid && !dCr;
	assign dInfo = deviceToHostValid && deviceToHostMsg.opcode == OP_AGENT_INFORMATION_MESSAGE;

	// Saturate first, then spend: a same-cycle grant may cover the send
	function automatic logic [7:0] crd(input logic [7:0] c, input logic a, input logic [7:0] n, input logic u);
		logic [8:0] s;
		s = {1'b0, c} + (a ? {1'b0, n} : 9'h000);
		if (s[8]) s = 9'h0ff;
		if (u && s != 9'h000) s = s - 9'h001;
		return s[7:0];
	endfunction

	always_comb begin
		gotCr_next = gotCr_reg | hCr;
		devCr_next = crd(devCr_reg, hCr, hostToDeviceMsg.payload[7:0], dUse);
		hostCr_next = crd(hostCr_reg, dCr, deviceToHostMsg.payload[7:0], hUse);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			gotCr_reg <= 1'b0;
			devCr_reg <= 8'h00;
			hostCr_reg <= 8'h00;
		end else begin
			gotCr_reg <= gotCr_next;
			devCr_reg <= devCr_next;
			hostCr_reg <= hostCr_next;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_tx_after_credit: assert property (deviceToHostValid |-> gotCr_reg)
		else $error("device sent before first host credit");
	// Grant is registered into state first, then into the output: two edges
	a_first_credit_count: assert property (hCr && !gotCr_reg |-> ##2
		(dCr && deviceToHostMsg.payload[7:0] == 8'(RX_DEPTH)))
		else $error("initial credit grant wrong");
	a_return_target_rsvd: assert property (dCr |-> deviceToHostMsg.payload[14:8] == AGENT_RSVD)
		else $error("target field not zero in credit return");
	a_info_revision: assert property (dInfo |-> deviceToHostMsg.paramIndex == PARAM_INDEX_REV &&
		deviceToHostMsg.payload[7:0] == DEV_REV && deviceToHostMsg.payload[127:8] == '0)
		else $error("agent_information_message reply content wrong");
	a_info_reply_bound: assert property (hInfo |-> ##[1:8] dInfo)
		else $error("no agent_information_message reply");
	a_credit_back_timely: assert property (hInfo |-> ##[1:HOLD_MAX]
		(dCr && deviceToHostMsg.payload[7:0] != 8'h00))
		else $error("credit withheld too long");
	a_host_within_credit: assert property (hUse |-> hostCr_reg != 8'h00 || dCr)
		else $error("host sent without credit");
	a_device_tx_blocked: assert property (dUse |-> devCr_reg != 8'h00 || hCr)
		else $error("device sent without credit");

	c_info_request: cover property (hInfo);
	c_host_last_credit: cover property (hUse && hostCr_reg == 8'h01);
	c_device_generic: cover property (dUse && deviceToHostMsg.opcode == OP_GENERIC);
endmodule

// ==== verif/pm_message_credit_init_test.sv ====
// Testbench joining both link ends back to back
`timescale 1ns/1ps
module pm_message_credit_init_test;
	import pm_msg_pkg::*;
	localparam int         RXD = 2;
	localparam logic [7:0] DEV_REV = 8'h03;
	localparam logic [7:0] HOST_REV = 8'h02;
	localparam logic [6:0] AGENT = 7'h2a;
	logic          ref_clk = 1'b0;
	logic          srst = 1'b1;
	logic          dTxValid = 1'b0, dTxReady, dRxValid, dRxReady = 1'b0, linkReady;
	logic          hTxValid = 1'b0, hTxReady, hRxValid, revMismatch, initDone;
	logic [127:0]  dTxPay = '0, hTxPay = '0;
	pm_msg_t       dRxMsg, hRxMsg;
	logic [6:0]    agentId;
	logic [7:0]    hostRevision;
	int            n_errors = 0;
	int            checks = 0;
	int            k, j;

	pm_msg_if link ();

	pm_msg_device #(.RX_DEPTH(RXD), .REVISION(DEV_REV)) u_pm_msg_device (
		.ref_clk(ref_clk), .srst(srst), .link(link),
		.userTxValid(dTxValid), .userTxPayload(dTxPay), .userTxReady(dTxReady),
		.userRxValid(dRxValid), .userRxMsg(dRxMsg), .userRxReady(dRxReady),
		.linkReady(linkReady), .agentId(agentId), .hostRevision(hostRevision)
	);
	pm_msg_host #(.HOST_CREDITS(4), .DEVICE_AGENT(AGENT), .REVISION(HOST_REV)) u_pm_msg_host (
		.ref_clk(ref_clk), .srst(srst), .link(link),
		.userTxValid(hTxValid), .userTxPayload(hTxPay), .userTxReady(hTxReady),
		.userRxValid(hRxValid), .userRxMsg(hRxMsg), .revMismatch(revMismatch), .initDone(initDone)
	);
	pm_msg_checker #(.RX_DEPTH(RXD), .DEV_REV(DEV_REV)) u_pm_msg_checker (
		.ref_clk(ref_clk), .srst(srst),
		.hostToDeviceValid(link.hostToDeviceValid), .hostToDeviceMsg(link.hostToDeviceMsg),
		.deviceToHostValid(link.deviceToHostValid), .deviceToHostMsg(link.deviceToHostMsg)
	);

	always #20 ref_clk = ~ref_clk;

	function automatic logic [127:0] pat(input int i);
		return {4{24'h3c96a5, i[7:0]}};
	endfunction

	task automatic end_sim();
		$display("errors=%0d checks=%0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic expire();
		n_errors++;
		$display("TIMEOUT t=%0t", $time);
		end_sim();
	endtask

	task automatic cmp_pay(input logic [127:0] got, input logic [127:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_init();
		for (int i = 0; i < 100; i++) begin
			@(posedge ref_clk);
			if (initDone === 1'b1 && linkReady === 1'b1) return;
		end
		expire();
	endtask

	// Valid stays up between sends; the caller drops it after the last one
	task automatic hsend(input logic [127:0] p);
		hTxPay <= p;
		if (hTxValid !== 1'b1) hTxValid <= 1'b1;
		for (int i = 0; i < 300; i++) begin
			@(posedge ref_clk);
			if (hTxReady === 1'b1) return;
		end
		expire();
	endtask

	task automatic dsend(input logic [127:0] p);
		dTxPay <= p;
		if (dTxValid !== 1'b1) dTxValid <= 1'b1;
		for (int i = 0; i < 300; i++) begin
			@(posedge ref_clk);
			if (dTxReady === 1'b1) return;
		end
		expire();
	endtask

	task automatic drecv(input logic [127:0] exp);
		for (int i = 0; i < 300; i++) begin
			@(posedge ref_clk);
			if (dRxValid === 1'b1 && dRxReady === 1'b1) begin
				cmp_pay(dRxMsg.payload, exp);
				cmp_val({4'h0, dRxMsg.opcode}, {4'h0, OP_GENERIC});
				return;
			end
		end
		expire();
	endtask

	task automatic hrecv(input logic [127:0] exp);
		for (int i = 0; i < 300; i++) begin
			@(posedge ref_clk);
			if (hRxValid === 1'b1) begin
				cmp_pay(hRxMsg.payload, exp);
				return;
			end
		end
		expire();
	endtask

	initial begin
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		wait_init();
		cmp_val({1'b0, agentId}, {1'b0, AGENT});
		cmp_val(hostRevision, HOST_REV);
		cmp_val({7'h00, revMismatch}, 8'h01);
		// Device sink stalled, so the host runs dry of credits
		fork
			begin
				for (k = 0; k < 4; k++) hsend(pat(k));
				hTxValid <= 1'b0;
			end
			begin
				repeat (30) @(posedge ref_clk);
				cmp_val({7'h00, hTxReady}, 8'h00);
				dRxReady <= 1'b1;
				for (j = 0; j < 4; j++) drecv(pat(j));
			end
		join
		fork
			begin
				for (k = 0; k < 6; k++) dsend(pat(k + 8));
				dTxValid <= 1'b0;
			end
			for (j = 0; j < 6; j++) hrecv(pat(j + 8));
		join
		// Reset in mid-run must restart the whole exchange
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		wait_init();
		cmp_val({1'b0, agentId}, {1'b0, AGENT});
		fork
			begin
				hsend(pat(20));
				hTxValid <= 1'b0;
			end
			drecv(pat(20));
		join
		end_sim();
	end
endmodule
